//--- src/szac_cfg.svh
`ifndef SZAC_CFG_SVH
`define SZAC_CFG_SVH

// ----------------------------------------------------------------
// write page sizes in bytes
// ----------------------------------------------------------------
`define SZAC_PAGE_LEN 7'h20
`define SZAC_AT_PAGE_LEN 7'h08

// ----------------------------------------------------------------
// attempt counters
// ----------------------------------------------------------------
`define SZAC_TRY_LIMIT 3'h4
`define SZAC_TRY_W 3
`define SZAC_NPWD 8
`define SZAC_AUTH_CTR 8

// ----------------------------------------------------------------
// configuration zone portions and special password
// ----------------------------------------------------------------
`define SZAC_PWD_PART 2'h3
`define SZAC_PWD_FUSE 2
`define SZAC_SUPER_PWD 3'h0
`define SZAC_LOCK_BYTE 3'h0

`endif

//--- src/szac_pkg.sv
package szac_pkg;

  // ----------------------------------------------------------------
  // decoded card commands from the frame layer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SZAC_OP_NONE = 4'h0,
    SZAC_OP_AUTH = 4'h1,
    SZAC_OP_ENC = 4'h2,
    SZAC_OP_PWD = 4'h3,
    SZAC_OP_READ = 4'h4,
    SZAC_OP_WRITE = 4'h5,
    SZAC_OP_CFG_WR = 4'h6,
    SZAC_OP_FUSE = 4'h7,
    SZAC_OP_RELEASE = 4'h8,
    SZAC_OP_STANDBY = 4'h9,
    SZAC_OP_CSUM = 4'ha
  } szac_op_e;

  // ----------------------------------------------------------------
  // write sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    SZAC_ST_BOOT = 7'h01,
    SZAC_ST_IDLE = 7'h02,
    SZAC_ST_DATA = 7'h04,
    SZAC_ST_BUF = 7'h08,
    SZAC_ST_COPY = 7'h10,
    SZAC_ST_DIRECT = 7'h20,
    SZAC_ST_RESTORE = 7'h40
  } szac_state_e;

  // ----------------------------------------------------------------
  // communication security mode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SZAC_MODE_STD = 3'h1,
    SZAC_MODE_AUTH = 3'h2,
    SZAC_MODE_ENC = 3'h4
  } szac_mode_e;

endpackage : szac_pkg

//--- src/szac_try_ctr.sv
`include "szac_cfg.svh"

module szac_try_ctr (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // one verification attempt
  input wire logic try_stb,
  input wire logic try_ok,
  // result
  output logic locked,
  output logic pass
);

  logic [`SZAC_TRY_W-1:0] fails_ff;
  logic [`SZAC_TRY_W-1:0] nxt_fails;

  // once at the limit every attempt fails and the count is frozen
  assign locked = (fails_ff == `SZAC_TRY_LIMIT);
  assign pass = try_ok & ~locked;

  always_comb begin
    nxt_fails = fails_ff;
    if (try_stb && !locked) begin
      nxt_fails = try_ok ? '0 : fails_ff + `SZAC_TRY_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fails_ff <= '0;
    end else begin
      fails_ff <= nxt_fails;
    end
  end

endmodule : szac_try_ctr

//--- src/szac_byte_chk.sv
`include "szac_cfg.svh"

module szac_byte_chk (
  // zone options
  input wire logic lock_mode,
  input wire logic prog_only,
  // byte under write
  input wire logic [2:0] byte_sel,
  input wire logic [7:0] lock_byte,
  input wire logic [7:0] old_data,
  input wire logic [7:0] new_data,
  // verdict
  output logic allow,
  output logic [7:0] merged
);

  logic is_lock_byte;
  logic only_clear;

  assign is_lock_byte = lock_mode & (byte_sel == `SZAC_LOCK_BYTE);
  // bit n guards byte n; bit 0 therefore guards the lock byte itself
  assign allow = ~lock_mode | lock_byte[byte_sel];
  assign only_clear = prog_only | is_lock_byte;
  // in program-only zones and on the lock byte, cleared bits can never come back to one
  assign merged = only_clear ? (old_data & new_data) : new_data;

endmodule : szac_byte_chk

//--- src/szac_top.sv
// Summary of operation
// - after power-up and anticollision the card is in standard mode, nothing held.
// - authentication mode on good authentication; encryption only after that.
// - config data clear; passwords encrypted from auth; user data in encryption.
// - three fuses each lock a config portion forever; blow them in order (the fuse command does not check the order).
// - antitearing chosen by host; pages at most 8 bytes, extra write cycles.
// - antitearing writes go to buffer then target; torn copy restored at boot.
// - in write-lock zones bit n of a page's first byte guards byte n.
// - clearing bit 0 of the lock byte locks the lock byte too.
// - lock byte bits only go from one to zero.
// - write-lock zones take one byte per write; more bytes are refused.
// - an accepted password holds until power loss, new password, release or standby.
// - one password active; a write password also grants read.
// - authentication holds until new attempt, failure, release or standby.
// - separate failure counters; after four misses every attempt fails.
// - encryption holds until re-init, new authentication attempt, release or standby; failed re-init stops user data ciphering.
// - zones needing encryption refuse reads and writes outside encryption mode.
// - authentication switches to MAC; writes then need a correct MAC.
// - wrong MAC abandons the command and drops MAC mode.
// - in standard mode the host may read a checksum back.
// - supervisor password holder gets full access to all password sets.
// - modify-forbidden zones refuse every write.
// - program-only zones only let bits go from one to zero.
// - without antitearing the write page is 32 bytes.
`include "szac_cfg.svh"

module szac_top (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // session
  input wire logic ac_done,
  // decoded command
  input wire logic cmd_valid,
  input wire szac_pkg::szac_op_e cmd_op,
  input wire logic cmd_ok,
  input wire logic cmd_mac_ok,
  input wire logic [2:0] cmd_pwd_idx,
  input wire logic cmd_pwd_wr,
  input wire logic [8:0] cmd_addr,
  input wire logic [5:0] cmd_len,
  input wire logic [1:0] cmd_part,
  input wire logic cmd_at,
  // options of the addressed zone
  input wire logic zc_pwd_en,
  input wire logic [2:0] zc_pwd_idx,
  input wire logic zc_auth_req,
  input wire logic zc_enc_req,
  input wire logic zc_lock_mode,
  input wire logic zc_prog_only,
  input wire logic zc_mod_forbid,
  input wire logic supervisor_en,
  input wire logic [2:0] fuse_blown,
  // write byte stream
  input wire logic wb_valid,
  input wire logic [7:0] wb_data,
  input wire logic [7:0] wb_old,
  input wire logic [7:0] lock_byte,
  // eeprom side
  input wire logic ee_done,
  input wire logic tear_pending,
  // answer
  output logic rsp_ack_ff,
  output logic rsp_nack_ff,
  output logic rd_grant_ff,
  output logic csum_rd_ff,
  // security state
  output logic [2:0] sec_mode_ff,
  output logic mac_mode_ff,
  output logic crypt_pwd_ff,
  output logic crypt_user_ff,
  output logic pwd_valid_ff,
  output logic [2:0] pwd_idx_ff,
  output logic pwd_wr_ff,
  // eeprom control
  output logic ee_wb_valid_ff,
  output logic [7:0] ee_wb_data_ff,
  output logic ee_prog_ff,
  output logic ee_to_buf_ff,
  output logic ee_from_buf_ff,
  output logic tear_set_ff,
  output logic tear_clr_ff,
  output logic [2:0] fuse_blow_ff,
  output logic busy_ff
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  szac_pkg::szac_state_e state_ff;
  szac_pkg::szac_state_e nxt_state;
  logic auth_ff;
  logic enc_ff;
  logic nxt_auth;
  logic nxt_enc;
  logic nxt_mac;
  logic nxt_pwd_valid;
  logic [2:0] nxt_pwd_idx;
  logic nxt_pwd_wr;
  logic at_ff;
  logic cfg_ff;
  logic lock_ff;
  logic prog_ff;
  logic [2:0] sel_ff;
  logic [5:0] cnt_ff;
  logic nxt_at;
  logic nxt_cfg;
  logic nxt_lock;
  logic nxt_prog;
  logic [2:0] nxt_sel;
  logic [5:0] nxt_cnt;
  logic nxt_ack;
  logic nxt_nack;
  logic nxt_rd_grant;
  logic nxt_csum;
  logic nxt_wb_valid;
  logic nxt_prog_pulse;
  logic nxt_to_buf;
  logic nxt_from_buf;
  logic nxt_tear_set;
  logic nxt_tear_clr;
  logic [2:0] nxt_fuse;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic take;
  logic op_auth;
  logic op_enc;
  logic op_pwd;
  logic op_read;
  logic op_write;
  logic op_cfg;
  logic op_fuse;
  logic op_release;
  logic op_csum;

  // commands only exist once anticollision is over
  assign take = cmd_valid & ac_done & (state_ff == szac_pkg::SZAC_ST_IDLE);
  assign op_auth = take & (cmd_op == szac_pkg::SZAC_OP_AUTH);
  assign op_enc = take & (cmd_op == szac_pkg::SZAC_OP_ENC);
  assign op_pwd = take & (cmd_op == szac_pkg::SZAC_OP_PWD);
  assign op_read = take & (cmd_op == szac_pkg::SZAC_OP_READ);
  assign op_write = take & (cmd_op == szac_pkg::SZAC_OP_WRITE);
  assign op_cfg = take & (cmd_op == szac_pkg::SZAC_OP_CFG_WR);
  assign op_fuse = take & (cmd_op == szac_pkg::SZAC_OP_FUSE);
  assign op_csum = take & (cmd_op == szac_pkg::SZAC_OP_CSUM);
  assign op_release = take & ((cmd_op == szac_pkg::SZAC_OP_RELEASE) |
                              (cmd_op == szac_pkg::SZAC_OP_STANDBY));

  // ----------------------------------------------------------------
  // attempt counters: one per password set plus authentication
  // ----------------------------------------------------------------
  logic [`SZAC_NPWD:0] try_stb;
  logic [`SZAC_NPWD:0] try_pass;

  genvar gi;
  generate
    for (gi = 0; gi < `SZAC_NPWD; gi++) begin : g_pwd_ctr
      assign try_stb[gi] = op_pwd & (cmd_pwd_idx == 3'(gi));
    end
  endgenerate
  assign try_stb[`SZAC_AUTH_CTR] = op_auth;

  generate
    for (gi = 0; gi <= `SZAC_NPWD; gi++) begin : g_ctr
      szac_try_ctr u_ctr (
        .clk(clk),
        .rstn(rstn),
        .try_stb(try_stb[gi]),
        .try_ok(cmd_ok),
        .locked(),
        .pass(try_pass[gi])
      );
    end
  endgenerate

  logic auth_pass;
  logic pwd_pass;

  assign auth_pass = try_pass[`SZAC_AUTH_CTR];
  assign pwd_pass = try_pass[cmd_pwd_idx];

  // ----------------------------------------------------------------
  // access checks
  // ----------------------------------------------------------------
  logic pwd_match;
  logic rd_ok;
  logic wr_ok;
  logic mac_bad;
  logic [6:0] lim;
  logic [6:0] off;
  logic [6:0] end_off;
  logic len_ok;
  logic super_ok;
  logic cfg_ok;

  assign pwd_match = pwd_valid_ff & (pwd_idx_ff == zc_pwd_idx);
  // a write password opens reads as well
  assign rd_ok = (~zc_pwd_en | pwd_match) & (~zc_auth_req | auth_ff) &
                 (~zc_enc_req | enc_ff);
  assign mac_bad = mac_mode_ff & ~cmd_mac_ok;
  assign lim = cmd_at ? `SZAC_AT_PAGE_LEN : `SZAC_PAGE_LEN;
  assign off = cmd_at ? {4'h0, cmd_addr[2:0]} : {2'h0, cmd_addr[4:0]};
  assign end_off = off + {1'b0, cmd_len};
  // a write may not cross its page; lock zones take a single byte
  assign len_ok = (cmd_len != 6'h00) & (end_off <= lim) &
                  (~zc_lock_mode | (cmd_len == 6'h01));
  assign wr_ok = (~zc_pwd_en | (pwd_match & pwd_wr_ff)) &
                 (~zc_auth_req | auth_ff) & (~zc_enc_req | enc_ff) &
                 ~zc_mod_forbid & len_ok;
  assign super_ok = supervisor_en & pwd_valid_ff & pwd_wr_ff &
                    (pwd_idx_ff == `SZAC_SUPER_PWD);
  // passwords are shielded by the last fuse unless the supervisor writes
  assign cfg_ok = (cmd_part == `SZAC_PWD_PART) ?
                  (~fuse_blown[`SZAC_PWD_FUSE] | super_ok) :
                  ~fuse_blown[cmd_part];

  // ----------------------------------------------------------------
  // per byte lock and program-only handling
  // ----------------------------------------------------------------
  logic byte_allow;
  logic [7:0] byte_merged;

  szac_byte_chk u_byte_chk (
    .lock_mode(lock_ff),
    .prog_only(prog_ff),
    .byte_sel(sel_ff),
    .lock_byte(lock_byte),
    .old_data(wb_old),
    .new_data(wb_data),
    .allow(byte_allow),
    .merged(byte_merged)
  );

  logic last_byte;

  assign last_byte = (cnt_ff == 6'h01);

  // ----------------------------------------------------------------
  // security state and write sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_auth = auth_ff;
    nxt_enc = enc_ff;
    nxt_mac = mac_mode_ff;
    nxt_pwd_valid = pwd_valid_ff;
    nxt_pwd_idx = pwd_idx_ff;
    nxt_pwd_wr = pwd_wr_ff;
    nxt_at = at_ff;
    nxt_cfg = cfg_ff;
    nxt_lock = lock_ff;
    nxt_prog = prog_ff;
    nxt_sel = sel_ff;
    nxt_cnt = cnt_ff;
    nxt_ack = 1'b0;
    nxt_nack = 1'b0;
    nxt_rd_grant = 1'b0;
    nxt_csum = 1'b0;
    nxt_wb_valid = 1'b0;
    nxt_prog_pulse = 1'b0;
    nxt_to_buf = ee_to_buf_ff;
    nxt_from_buf = ee_from_buf_ff;
    nxt_tear_set = 1'b0;
    nxt_tear_clr = 1'b0;
    nxt_fuse = 3'h0;
    unique case (state_ff)
      szac_pkg::SZAC_ST_BOOT: begin
        // a torn copy is finished from the buffer before anything else
        if (tear_pending) begin
          nxt_prog_pulse = 1'b1;
          nxt_from_buf = 1'b1;
          nxt_to_buf = 1'b0;
          nxt_state = szac_pkg::SZAC_ST_RESTORE;
        end else begin
          nxt_state = szac_pkg::SZAC_ST_IDLE;
        end
      end
      szac_pkg::SZAC_ST_RESTORE: begin
        if (ee_done) begin
          nxt_tear_clr = 1'b1;
          nxt_from_buf = 1'b0;
          nxt_state = szac_pkg::SZAC_ST_IDLE;
        end
      end
      szac_pkg::SZAC_ST_IDLE: begin
        if (op_auth) begin
          // a new attempt drops the old session first
          nxt_auth = auth_pass;
          nxt_mac = auth_pass;
          nxt_enc = 1'b0;
          nxt_ack = auth_pass;
          nxt_nack = ~auth_pass;
        end
        if (op_enc) begin
          nxt_enc = auth_ff & cmd_ok;
          nxt_ack = auth_ff & cmd_ok;
          nxt_nack = ~(auth_ff & cmd_ok);
        end
        if (op_pwd) begin
          // presenting a password replaces whatever was active
          nxt_pwd_valid = pwd_pass;
          nxt_pwd_idx = cmd_pwd_idx;
          nxt_pwd_wr = cmd_pwd_wr;
          nxt_ack = pwd_pass;
          nxt_nack = ~pwd_pass;
        end
        if (op_release) begin
          nxt_auth = 1'b0;
          nxt_enc = 1'b0;
          nxt_mac = 1'b0;
          nxt_pwd_valid = 1'b0;
          nxt_ack = 1'b1;
        end
        if (op_read) begin
          nxt_rd_grant = rd_ok;
          nxt_ack = rd_ok;
          nxt_nack = ~rd_ok;
        end
        if (op_csum) begin
          nxt_csum = ~mac_mode_ff;
          nxt_ack = ~mac_mode_ff;
          nxt_nack = mac_mode_ff;
        end
        if (op_fuse) begin
          nxt_fuse[cmd_part] = (cmd_part != `SZAC_PWD_PART);
          nxt_ack = (cmd_part != `SZAC_PWD_PART);
          nxt_nack = (cmd_part == `SZAC_PWD_PART);
        end
        if ((op_write | op_cfg) & mac_bad) begin
          nxt_mac = 1'b0;
          nxt_nack = 1'b1;
        end else if ((op_write & wr_ok) | (op_cfg & cfg_ok & len_ok)) begin
          nxt_at = cmd_at;
          nxt_cfg = op_cfg;
          nxt_lock = op_write & zc_lock_mode;
          nxt_prog = op_write & zc_prog_only;
          nxt_sel = cmd_addr[2:0];
          nxt_cnt = cmd_len;
          nxt_state = szac_pkg::SZAC_ST_DATA;
        end else if (op_write | op_cfg) begin
          nxt_nack = 1'b1;
        end
      end
      szac_pkg::SZAC_ST_DATA: begin
        if (wb_valid & ~byte_allow) begin
          nxt_nack = 1'b1;
          nxt_state = szac_pkg::SZAC_ST_IDLE;
        end else if (wb_valid) begin
          nxt_wb_valid = 1'b1;
          nxt_cnt = cnt_ff - 6'h01;
          nxt_sel = sel_ff + 3'h1;
          if (last_byte) begin
            nxt_prog_pulse = 1'b1;
            nxt_to_buf = at_ff;
            nxt_from_buf = 1'b0;
            nxt_state = at_ff ? szac_pkg::SZAC_ST_BUF :
                                szac_pkg::SZAC_ST_DIRECT;
          end
        end
      end
      szac_pkg::SZAC_ST_BUF: begin
        // buffer holds a good copy: mark it in the same cycle the target copy starts
        if (ee_done) begin
          nxt_tear_set = 1'b1;
          nxt_prog_pulse = 1'b1;
          nxt_to_buf = 1'b0;
          nxt_from_buf = 1'b1;
          nxt_state = szac_pkg::SZAC_ST_COPY;
        end
      end
      szac_pkg::SZAC_ST_COPY: begin
        if (ee_done) begin
          nxt_tear_clr = 1'b1;
          nxt_from_buf = 1'b0;
          nxt_ack = 1'b1;
          nxt_state = szac_pkg::SZAC_ST_IDLE;
        end
      end
      szac_pkg::SZAC_ST_DIRECT: begin
        if (ee_done) begin
          nxt_ack = 1'b1;
          nxt_state = szac_pkg::SZAC_ST_IDLE;
        end
      end
      default: begin
        nxt_state = szac_pkg::SZAC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // mode and cipher selection
  // ----------------------------------------------------------------
  logic [2:0] nxt_mode;

  assign nxt_mode = nxt_enc ? szac_pkg::SZAC_MODE_ENC :
                    nxt_auth ? szac_pkg::SZAC_MODE_AUTH :
                    szac_pkg::SZAC_MODE_STD;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= szac_pkg::SZAC_ST_BOOT;
      auth_ff <= 1'b0;
      enc_ff <= 1'b0;
      mac_mode_ff <= 1'b0;
      sec_mode_ff <= szac_pkg::SZAC_MODE_STD;
      crypt_pwd_ff <= 1'b0;
      crypt_user_ff <= 1'b0;
      pwd_valid_ff <= 1'b0;
      pwd_idx_ff <= 3'h0;
      pwd_wr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      auth_ff <= nxt_auth;
      enc_ff <= nxt_enc;
      mac_mode_ff <= nxt_mac;
      sec_mode_ff <= nxt_mode;
      crypt_pwd_ff <= nxt_auth | nxt_enc;
      crypt_user_ff <= nxt_enc;
      pwd_valid_ff <= nxt_pwd_valid;
      pwd_idx_ff <= nxt_pwd_idx;
      pwd_wr_ff <= nxt_pwd_wr;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      at_ff <= 1'b0;
      cfg_ff <= 1'b0;
      lock_ff <= 1'b0;
      prog_ff <= 1'b0;
      sel_ff <= 3'h0;
      cnt_ff <= 6'h00;
      ee_to_buf_ff <= 1'b0;
      ee_from_buf_ff <= 1'b0;
      ee_wb_data_ff <= 8'h00;
    end else begin
      at_ff <= nxt_at;
      cfg_ff <= nxt_cfg;
      lock_ff <= nxt_lock;
      prog_ff <= nxt_prog;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      ee_to_buf_ff <= nxt_to_buf;
      ee_from_buf_ff <= nxt_from_buf;
      if (nxt_wb_valid) begin
        ee_wb_data_ff <= byte_merged;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_ack_ff <= 1'b0;
      rsp_nack_ff <= 1'b0;
      rd_grant_ff <= 1'b0;
      csum_rd_ff <= 1'b0;
      ee_wb_valid_ff <= 1'b0;
      ee_prog_ff <= 1'b0;
      tear_set_ff <= 1'b0;
      tear_clr_ff <= 1'b0;
      fuse_blow_ff <= 3'h0;
      busy_ff <= 1'b1;
    end else begin
      rsp_ack_ff <= nxt_ack;
      rsp_nack_ff <= nxt_nack;
      rd_grant_ff <= nxt_rd_grant;
      csum_rd_ff <= nxt_csum;
      ee_wb_valid_ff <= nxt_wb_valid;
      ee_prog_ff <= nxt_prog_pulse;
      tear_set_ff <= nxt_tear_set;
      tear_clr_ff <= nxt_tear_clr;
      fuse_blow_ff <= nxt_fuse;
      busy_ff <= (nxt_state != szac_pkg::SZAC_ST_IDLE);
    end
  end

endmodule : szac_top

//--- test/szac_monitor.sv
module szac_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command side
  input wire logic ac_done,
  input wire logic cmd_valid,
  input wire szac_pkg::szac_op_e cmd_op,
  input wire logic cmd_mac_ok,
  input wire logic [5:0] cmd_len,
  input wire logic zc_lock_mode,
  input wire logic zc_mod_forbid,
  // answer and state
  input wire logic busy_ff,
  input wire logic rsp_ack_ff,
  input wire logic rsp_nack_ff,
  input wire logic csum_rd_ff,
  input wire logic [2:0] sec_mode_ff,
  input wire logic mac_mode_ff,
  input wire logic crypt_user_ff,
  input wire logic pwd_valid_ff
);
  logic take;
  logic wr;
  assign take = cmd_valid && ac_done && !busy_ff;
  assign wr = take && cmd_op == szac_pkg::SZAC_OP_WRITE;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // security state
  // ----------------------------------------------------------------
  mode_onehot_a: assert property ($onehot(sec_mode_ff))
    else $error("security mode not one-hot");
  enc_after_auth_a: assert property ($rose(sec_mode_ff[2]) |->
    $past(sec_mode_ff[1])) else $error("encryption without auth");
  mac_with_auth_a: assert property ($rose(mac_mode_ff) |->
    !sec_mode_ff[0]) else $error("mac mode in standard mode");
  release_clears_a: assert property (take && cmd_op ==
    szac_pkg::SZAC_OP_RELEASE |=> sec_mode_ff == 3'h1 && !mac_mode_ff
    && !pwd_valid_ff && !crypt_user_ff) else $error("release kept state");
  csum_std_a: assert property (take && cmd_op ==
    szac_pkg::SZAC_OP_CSUM && !mac_mode_ff |=> csum_rd_ff)
    else $error("checksum readback missing");
  // ----------------------------------------------------------------
  // write refusals
  // ----------------------------------------------------------------
  long_write_a: assert property (wr && cmd_len > 6'h20 |=>
    rsp_nack_ff) else $error("oversize write taken");
  forbid_write_a: assert property (wr && zc_mod_forbid |=>
    rsp_nack_ff ##1 !rsp_ack_ff) else $error("forbidden zone written");
  lock_multi_a: assert property (wr && zc_lock_mode && cmd_len != 6'h01
    |=> rsp_nack_ff) else $error("multi-byte lock write taken");
  mac_bad_a: assert property (wr && mac_mode_ff && !cmd_mac_ok |=>
    rsp_nack_ff && !mac_mode_ff) else $error("bad mac not dropped");
endmodule : szac_monitor

bind szac_top szac_monitor u_szac_monitor (.*);

//--- test/szac_ee_model.sv
module szac_ee_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // program handshake
  input wire logic ee_prog,
  input wire logic slow,
  output logic ee_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  // one done per program pulse; slow mode mimics a long cell write
  assign nxt_cnt = ee_prog ? (slow ? 5'h13 : 5'h02) :
    (cnt_ff != 5'h00 ? cnt_ff - 5'h01 : cnt_ff);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 5'h00;
      ee_done <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ee_done <= cnt_ff == 5'h01;
    end
  end
endmodule : szac_ee_model

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ac_done, cmd_valid, cmd_ok, cmd_mac_ok, cmd_pwd_wr, cmd_at, slow;
  szac_pkg::szac_op_e cmd_op;
  logic [2:0] cmd_pwd_idx, zc_pwd_idx, fuse_blown, sec_mode_ff;
  logic [2:0] pwd_idx_ff, fuse_blow_ff;
  logic [8:0] cmd_addr;
  logic [5:0] cmd_len;
  logic [1:0] cmd_part;
  logic zc_pwd_en, zc_auth_req, zc_enc_req, zc_lock_mode, zc_prog_only;
  logic zc_mod_forbid, supervisor_en, wb_valid, ee_done, tear_pending;
  logic [7:0] wb_data, wb_old, lock_byte, ee_wb_data_ff;
  logic rsp_ack_ff, rsp_nack_ff, rd_grant_ff, csum_rd_ff, mac_mode_ff;
  logic crypt_pwd_ff, crypt_user_ff, pwd_valid_ff, pwd_wr_ff, busy_ff;
  logic ee_wb_valid_ff, ee_prog_ff, ee_to_buf_ff, ee_from_buf_ff;
  logic tear_set_ff, tear_clr_ff;
  int errors = 0;
  int checked = 0;
  logic rq[$];
  logic [7:0] dq[$];

  always #2 clk = ~clk;

  szac_top u_szac_top (.*);
  szac_ee_model u_szac_ee_model (.clk, .rstn, .ee_prog(ee_prog_ff), .slow,
    .ee_done);

  // ----------------------------------------------------------------
  // compares and closing
  // ----------------------------------------------------------------
  task automatic chk_v(logic [7:0] g, logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: value %h expected %h", $time, g, e);
    end
  endtask : chk_v
  task automatic chk_rsp(logic [1:0] g, logic [1:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: answer %b expected %b", $time, g, e);
    end
  endtask : chk_rsp
  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // outputs are flops, so the falling edge sees them settled
  always @(negedge clk) begin
    if (rsp_ack_ff === 1'b1 || rsp_nack_ff === 1'b1)
      chk_rsp({rsp_ack_ff, rsp_nack_ff},
        rq.size() ? (rq.pop_front() ? 2'b10 : 2'b01) : 2'b00);
    if (ee_wb_valid_ff === 1'b1)
      chk_v(ee_wb_data_ff, dq.size() ? dq.pop_front() : 8'hxx);
  end

  // ----------------------------------------------------------------
  // driver: command, byte stream, wait for idle
  // ----------------------------------------------------------------
  task automatic send(szac_pkg::szac_op_e op, int nb, logic e, logic am);
    rq.push_back(e);
    cmd_op = op;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (nb) begin
      wb_data = 8'($urandom);
      wb_old = 8'($urandom);
      if (e) dq.push_back(am ? wb_old & wb_data : wb_data);
      wb_valid = 1'b1;
      @(negedge clk);
    end
    wb_valid = 1'b0;
    for (int i = 0; i < 300 && busy_ff !== 1'b0; i++) @(negedge clk);
    @(negedge clk);
  endtask : send
  task automatic done(string s);
    $display("test %s done", s);
  endtask : done
  task automatic boot;
    rstn = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
  endtask : boot

  initial begin
    #40000;
    errors++;
    end_sim();
  end

  initial begin
    {ac_done, cmd_valid, cmd_ok, cmd_mac_ok, cmd_pwd_wr, cmd_at, slow} = '0;
    {zc_pwd_en, zc_auth_req, zc_enc_req, zc_lock_mode, zc_prog_only} = '0;
    {zc_mod_forbid, supervisor_en, wb_valid, tear_pending} = '0;
    {cmd_pwd_idx, zc_pwd_idx, fuse_blown, cmd_part} = '0;
    {wb_data, wb_old, lock_byte, cmd_addr} = '0;
    cmd_op = szac_pkg::SZAC_OP_NONE;
    cmd_len = 6'h01;
    void'($urandom(99));
    ac_done = 1'b1;
    boot();
    chk_v(8'(sec_mode_ff), 8'h01);
    cmd_addr = 9'($urandom);
    send(szac_pkg::SZAC_OP_WRITE, 1, 1'b1, 1'b0);
    zc_prog_only = 1'b1;
    send(szac_pkg::SZAC_OP_WRITE, 1, 1'b1, 1'b1);
    zc_prog_only = 1'b0;
    cmd_len = 6'h21;
    send(szac_pkg::SZAC_OP_WRITE, 0, 1'b0, 1'b0);
    {cmd_at, cmd_len, cmd_addr, slow} = {1'b1, 6'h09, 9'h080, 1'b1};
    send(szac_pkg::SZAC_OP_WRITE, 0, 1'b0, 1'b0);
    cmd_len = 6'h08;
    send(szac_pkg::SZAC_OP_WRITE, 8, 1'b1, 1'b0);
    chk_v({6'h00, ee_to_buf_ff, ee_from_buf_ff}, 8'h00);
    {cmd_at, cmd_len, slow, zc_mod_forbid} = {1'b0, 6'h01, 1'b0, 1'b1};
    send(szac_pkg::SZAC_OP_WRITE, 0, 1'b0, 1'b0);
    {zc_mod_forbid, zc_lock_mode, cmd_len} = {1'b0, 1'b1, 6'h02};
    send(szac_pkg::SZAC_OP_WRITE, 0, 1'b0, 1'b0);
    {cmd_len, lock_byte, cmd_addr} = {6'h01, 8'hd9, 9'h082};
    send(szac_pkg::SZAC_OP_WRITE, 1, 1'b0, 1'b0);
    cmd_addr = 9'h083;
    send(szac_pkg::SZAC_OP_WRITE, 1, 1'b1, 1'b0);
    cmd_addr = 9'h080;
    send(szac_pkg::SZAC_OP_WRITE, 1, 1'b1, 1'b1);
    lock_byte = 8'hd8;
    send(szac_pkg::SZAC_OP_WRITE, 1, 1'b0, 1'b0);
    zc_lock_mode = 1'b0;
    done("writes");
    send(szac_pkg::SZAC_OP_ENC, 0, 1'b0, 1'b0);
    cmd_ok = 1'b1;
    send(szac_pkg::SZAC_OP_AUTH, 0, 1'b1, 1'b0);
    chk_v({mac_mode_ff, crypt_pwd_ff, 3'h0, sec_mode_ff}, 8'hc2);
    send(szac_pkg::SZAC_OP_ENC, 0, 1'b1, 1'b0);
    chk_v({crypt_user_ff, 4'h0, sec_mode_ff}, 8'h84);
    zc_enc_req = 1'b1;
    send(szac_pkg::SZAC_OP_READ, 0, 1'b1, 1'b0);
    cmd_ok = 1'b0;
    send(szac_pkg::SZAC_OP_ENC, 0, 1'b0, 1'b0);
    chk_v(8'(crypt_user_ff), 8'h00);
    send(szac_pkg::SZAC_OP_READ, 0, 1'b0, 1'b0);
    zc_enc_req = 1'b0;
    send(szac_pkg::SZAC_OP_WRITE, 0, 1'b0, 1'b0);
    send(szac_pkg::SZAC_OP_CSUM, 0, 1'b1, 1'b0);
    send(szac_pkg::SZAC_OP_RELEASE, 0, 1'b1, 1'b0);
    chk_v(8'(sec_mode_ff), 8'h01);
    done("modes");
    repeat (4) send(szac_pkg::SZAC_OP_AUTH, 0, 1'b0, 1'b0);
    cmd_ok = 1'b1;
    send(szac_pkg::SZAC_OP_AUTH, 0, 1'b0, 1'b0);
    {cmd_pwd_idx, cmd_pwd_wr, zc_pwd_idx} = {3'h3, 1'b1, 3'h3};
    send(szac_pkg::SZAC_OP_PWD, 0, 1'b1, 1'b0);
    zc_pwd_en = 1'b1;
    send(szac_pkg::SZAC_OP_READ, 0, 1'b1, 1'b0);
    send(szac_pkg::SZAC_OP_STANDBY, 0, 1'b1, 1'b0);
    chk_v(8'(pwd_valid_ff), 8'h00);
    done("passwords");
    tear_pending = 1'b1;
    boot();
    chk_v({6'h00, ee_prog_ff, ee_from_buf_ff}, 8'h03);
    tear_pending = 1'b0;
    for (int i = 0; i < 300 && busy_ff !== 1'b0; i++) @(negedge clk);
    chk_v(8'(sec_mode_ff), 8'h01);
    done("restore");
    end_sim();
  end
endmodule : tb_top
